// >>> sbtc_pkg.sv
package sbtc_pkg;
  localparam logic [7:0] SBTC_CTRL_RESET = 8'h00;
  localparam int SBTC_BIT_RUN = 0;
  localparam int SBTC_BIT_SRC = 1;
  localparam int SBTC_BIT_SYNC_BYP = 2;
  localparam int SBTC_BIT_PAIR_LO = 3;
  localparam int SBTC_BIT_DIV_LO = 4;
  localparam int SBTC_BIT_DIV_HI = 5;
  localparam int SBTC_BIT_PAIR_HI = 6;
  localparam int SBTC_BIT_WIDE = 7;
  localparam logic [3:0] SBTC_TRIG_MODE = 4'hB;
  localparam logic [1:0] SBTC_INSTR_DIV = 2'h3;
  localparam logic [5:0] SBTC_OFF_CTRL = 6'h00;
  localparam logic [5:0] SBTC_OFF_LOW = 6'h04;
  localparam logic [5:0] SBTC_OFF_HIGH = 6'h08;
  localparam logic [5:0] SBTC_OFF_STATUS = 6'h0C;
  localparam logic [5:0] SBTC_OFF_MASK = 6'h10;
  localparam logic [1:0] SBTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SBTC_RESP_SLVERR = 2'h2;
endpackage

// >>> sbtc_top.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module sbtc_top (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_count_pin,
  input wire logic neighbour_osc,
  input wire logic neighbour_osc_en,
  input wire logic [3:0] capture_compare_mode_code,
  input wire logic ccp_uses_this_timer,
  input wire logic special_event,
  output logic [1:0] ccp_pair_select,
  output logic irq
);
  import sbtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] counter_control, next_counter_control;
  logic [15:0] count, next_count;
  logic [7:0] high_buffer, next_high_buffer;
  logic [2:0] prescale, next_prescale;
  logic [1:0] instr_phase, next_instr_phase;
  logic ext_s1, ext_s2, next_ext_s2, ext_prev, next_ext_prev, armed, next_armed;
  logic overflow_flag, next_overflow_flag, overflow_mask, next_overflow_mask;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [5:0] waddr, next_waddr, raddr_hold;
  logic [31:0] wdata, next_wdata, rdata_q, next_rdata;
  logic wen, next_wen;
  logic [1:0] bresp_q, next_bresp, rresp_q, next_rresp;
  logic have_aw, next_have_aw, have_w, next_have_w;
  logic irq_q, next_irq;

  ////////////////////////////////////////////////////////////////////////
  // Count source, prescale and edges
  logic ext_raw, ext_level, ext_rise, ext_fall, src_tick, div_tick;
  logic [2:0] div_mask;
  logic do_write, do_read, wr_ctrl, wr_low, wr_high, wr_stat, wr_mask, rd_low;
  logic trigger;

  always_comb begin
    ext_raw = neighbour_osc_en ? neighbour_osc : external_count_pin;
    ext_level = counter_control[SBTC_BIT_SYNC_BYP] ? ext_raw : ext_s2;
    ext_rise = ext_level && !ext_prev && armed;
    ext_fall = !ext_level && ext_prev;
    if (counter_control[SBTC_BIT_SRC]) begin
      src_tick = ext_rise;
    end else begin
      src_tick = (instr_phase == SBTC_INSTR_DIV);
    end
    case ({counter_control[SBTC_BIT_DIV_HI], counter_control[SBTC_BIT_DIV_LO]})
      2'b00: div_mask = 3'h0;
      2'b01: div_mask = 3'h1;
      2'b10: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
    div_tick = src_tick && ((prescale & div_mask) == div_mask);
    trigger = special_event && ccp_uses_this_timer &&
              (capture_compare_mode_code == SBTC_TRIG_MODE);
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  always_comb begin
    do_write = have_aw && have_w && !bvalid_q;
    do_read = arready_q && s_axi_arvalid;
    wr_ctrl = do_write && wen && (waddr == SBTC_OFF_CTRL);
    wr_low = do_write && wen && (waddr == SBTC_OFF_LOW);
    wr_high = do_write && wen && (waddr == SBTC_OFF_HIGH);
    wr_stat = do_write && wen && (waddr == SBTC_OFF_STATUS);
    wr_mask = do_write && wen && (waddr == SBTC_OFF_MASK);
    rd_low = do_read && (s_axi_araddr == SBTC_OFF_LOW);
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  logic wide;
  always_comb begin
    wide = counter_control[SBTC_BIT_WIDE];
    next_counter_control = wr_ctrl ? wdata[7:0] : counter_control;
    next_instr_phase = instr_phase + 2'h1;
    next_ext_s2 = ext_s1;
    next_ext_prev = ext_level;
    next_armed = armed || ext_fall;
    next_prescale = prescale;
    next_count = count;
    next_high_buffer = high_buffer;
    // Clear first so that a same-cycle overflow still sets the flag
    next_overflow_flag = (wr_stat && wdata[0]) ? 1'b0 : overflow_flag;
    if (counter_control[SBTC_BIT_RUN] && div_tick) begin
      next_count = count + 16'h0001;
      if (count == 16'hFFFF && !trigger) begin
        next_overflow_flag = 1'b1;
      end
    end
    if (counter_control[SBTC_BIT_RUN] && src_tick) begin
      next_prescale = prescale + 3'h1;
    end
    if (trigger && !wr_low && !(wr_high && !wide)) begin
      next_count = 16'h0000;
      next_prescale = 3'h0;
    end
    if (rd_low && wide) begin
      next_high_buffer = count[15:8];
    end
    if (wr_high) begin
      if (wide) begin
        next_high_buffer = wdata[7:0];
      end else begin
        next_count[15:8] = wdata[7:0];
      end
    end
    if (wr_low) begin
      next_count[7:0] = wdata[7:0];
      if (wide) begin
        next_count[15:8] = high_buffer;
      end
      next_prescale = 3'h0;
    end
    next_overflow_mask = wr_mask ? wdata[0] : overflow_mask;
    next_irq = next_overflow_flag && next_overflow_mask;
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes
  always_comb begin
    next_have_aw = have_aw;
    next_have_w = have_w;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wen = wen;
    next_awready = awready_q;
    next_wready = wready_q;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    if (awready_q && s_axi_awvalid) begin
      next_have_aw = 1'b1;
      next_awready = 1'b0;
      next_waddr = s_axi_awaddr;
    end
    if (wready_q && s_axi_wvalid) begin
      next_have_w = 1'b1;
      next_wready = 1'b0;
      next_wdata = s_axi_wdata;
      next_wen = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_bvalid = 1'b1;
      next_have_aw = 1'b0;
      next_have_w = 1'b0;
      next_bresp = (waddr[1:0] == 2'h0 && waddr <= SBTC_OFF_MASK) ?
                   SBTC_RESP_OKAY : SBTC_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    next_arready = arready_q;
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (do_read) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = SBTC_RESP_OKAY;
      case (s_axi_araddr)
        SBTC_OFF_CTRL: next_rdata = {24'h0, counter_control};
        SBTC_OFF_LOW: next_rdata = {24'h0, count[7:0]};
        SBTC_OFF_HIGH: next_rdata = {24'h0, wide ? high_buffer : count[15:8]};
        SBTC_OFF_STATUS: next_rdata = {31'h0, overflow_flag};
        SBTC_OFF_MASK: next_rdata = {31'h0, overflow_mask};
        default: begin
          next_rdata = 32'h0;
          next_rresp = SBTC_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      counter_control <= SBTC_CTRL_RESET;
      count <= 16'h0000;
      high_buffer <= 8'h00;
      prescale <= 3'h0;
      instr_phase <= 2'h0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
      armed <= 1'b0;
      overflow_flag <= 1'b0;
      overflow_mask <= 1'b0;
      irq_q <= 1'b0;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      waddr <= 6'h00;
      wdata <= 32'h0;
      wen <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= SBTC_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= SBTC_RESP_OKAY;
    end else if (clk_en) begin
      counter_control <= next_counter_control;
      count <= next_count;
      high_buffer <= next_high_buffer;
      prescale <= next_prescale;
      instr_phase <= next_instr_phase;
      ext_s1 <= ext_raw;
      ext_s2 <= next_ext_s2;
      ext_prev <= next_ext_prev;
      armed <= next_armed;
      overflow_flag <= next_overflow_flag;
      overflow_mask <= next_overflow_mask;
      irq_q <= next_irq;
      have_aw <= next_have_aw;
      have_w <= next_have_w;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wen <= next_wen;
      awready_q <= next_awready;
      wready_q <= next_wready;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      arready_q <= next_arready;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    s_axi_awready = awready_q;
    s_axi_wready = wready_q;
    s_axi_bvalid = bvalid_q;
    s_axi_bresp = bresp_q;
    s_axi_arready = arready_q;
    s_axi_rvalid = rvalid_q;
    s_axi_rdata = rdata_q;
    s_axi_rresp = rresp_q;
    ccp_pair_select = {counter_control[SBTC_BIT_PAIR_HI],
                       counter_control[SBTC_BIT_PAIR_LO]};
    irq = irq_q;
  end
endmodule // sbtc_top

// >>> sbtc_properties.sv
`timescale 1ns/1ns
module sbtc_properties
  import sbtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  logic [5:0] aw_q;
  logic [5:0] next_aw_q;
  function automatic logic bad(input logic [5:0] a);
    return a[1:0] != 2'h0 || a > SBTC_OFF_MASK;
  endfunction
  always_comb begin
    next_aw_q = aw_q;
    if (s_axi_awvalid && s_axi_awready) next_aw_q = s_axi_awaddr;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) aw_q <= 6'h00;
    else aw_q <= next_aw_q;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped early");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_bad_read: assert property (s_axi_arvalid && s_axi_arready && bad(s_axi_araddr)
    |=> s_axi_rresp == SBTC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
  chk_write_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
    (bad(aw_q) ? SBTC_RESP_SLVERR : SBTC_RESP_OKAY)) else $error("wrong bresp");
  chk_irq_clear: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq fell without write");
  cov_irq: cover property ($rose(irq));
  cov_bad: cover property (s_axi_arvalid && s_axi_arready && bad(s_axi_araddr));
  cov_wr: cover property ($rose(s_axi_bvalid));
endmodule // sbtc_properties

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import sbtc_pkg::*;
  logic mclk = 1'h0, rstn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, special_event = 1'h0;
  logic external_count_pin = 1'h0, neighbour_osc = 1'h0, neighbour_osc_en = 1'h0;
  logic clk_en = 1'h1, ccp_uses_this_timer = 1'h1;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] capture_compare_mode_code = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, ccp_pair_select, resp;
  logic [31:0] s_axi_rdata, rd_val;
  int err_total = 0;
  int comparisons = 0;
  int n;
  always #25 mclk = ~mclk;
  sbtc_top sbtc_top_i (.mclk, .rstn, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_count_pin, .neighbour_osc, .neighbour_osc_en, .capture_compare_mode_code,
    .ccp_uses_this_timer, .special_event, .ccp_pair_select, .irq);
  //////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hang;
    err_total++;
    stop_test;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (k = 0; k < 50 && !(s_axi_bvalid && s_axi_bready); k++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
    if (k == 50) hang;
  endtask
  task rd(input logic [5:0] a);
    int k;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (k = 0; k < 50 && !(s_axi_rvalid && s_axi_rready); k++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
    if (k == 50) hang;
  endtask
  task rdc(input string nm, input logic [5:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, {24'h0, e}, rd_val);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'h1;
    rdc("control", SBTC_OFF_CTRL, SBTC_CTRL_RESET);
    chk("irq", 32'h0, 32'(irq));
    for (int i = 0; i < 4; i++) begin
      wr(SBTC_OFF_CTRL, {1'h0, i[1], 2'h0, i[0], 3'h0});
      chk("pair", 32'(i), 32'(ccp_pair_select));
      rdc("control", SBTC_OFF_CTRL, {1'h0, i[1], 2'h0, i[0], 3'h0});
    end
    wr(SBTC_OFF_CTRL, 8'h00);
    wr(SBTC_OFF_LOW, 8'h5A);
    wr(SBTC_OFF_HIGH, 8'hA5);
    repeat (40) @(posedge mclk);
    rdc("low", SBTC_OFF_LOW, 8'h5A);
    rdc("high", SBTC_OFF_HIGH, 8'hA5);
    // Ticks near 260 cycles over four times the divider
    for (int d = 0; d < 4; d++) begin
      wr(SBTC_OFF_LOW, 8'h00);
      wr(SBTC_OFF_CTRL, {2'h0, d[1:0], 4'h1});
      repeat (256) @(posedge mclk);
      wr(SBTC_OFF_CTRL, 8'h00);
      rd(SBTC_OFF_LOW);
      chk("ticks", 32'h1, 32'(rd_val >= (64 >> d) - 1 && rd_val <= (64 >> d) + 2));
    end
    // Clock enable low freezes the running counter
    wr(SBTC_OFF_LOW, 8'h00);
    wr(SBTC_OFF_CTRL, 8'h01);
    clk_en <= 1'h0;
    repeat (100) @(posedge mclk);
    clk_en <= 1'h1;
    wr(SBTC_OFF_CTRL, 8'h00);
    rd(SBTC_OFF_LOW);
    chk("freeze", 32'h1, 32'(rd_val <= 2));
    wr(SBTC_OFF_MASK, 8'h01);
    wr(SBTC_OFF_HIGH, 8'hFF);
    wr(SBTC_OFF_LOW, 8'hFE);
    wr(SBTC_OFF_CTRL, 8'h01);
    for (n = 0; n < 100 && irq !== 1'h1; n++) @(posedge mclk);
    if (n == 100) hang;
    wr(SBTC_OFF_CTRL, 8'h00);
    rdc("status", SBTC_OFF_STATUS, 8'h01);
    rdc("high", SBTC_OFF_HIGH, 8'h00);
    wr(SBTC_OFF_MASK, 8'h00);
    repeat (2) @(posedge mclk);
    chk("irq", 32'h0, 32'(irq));
    rdc("status", SBTC_OFF_STATUS, 8'h01);
    wr(SBTC_OFF_STATUS, 8'h01);
    rdc("status", SBTC_OFF_STATUS, 8'h00);
    wr(SBTC_OFF_LOW, 8'h50);
    for (int m = 10; m < 12; m++) begin
      capture_compare_mode_code <= m[3:0];
      special_event <= 1'h1;
      @(posedge mclk);
      special_event <= 1'h0;
      rdc("trigger", SBTC_OFF_LOW, m == 11 ? 8'h00 : 8'h50);
    end
    rdc("status", SBTC_OFF_STATUS, 8'h00);
    // Trigger in the very cycle of a low-byte write loses to the write
    fork
      wr(SBTC_OFF_LOW, 8'h66);
      begin
        repeat (2) @(posedge mclk);
        special_event <= 1'h1;
        @(posedge mclk);
        special_event <= 1'h0;
      end
    join
    rdc("trig_vs_write", SBTC_OFF_LOW, 8'h66);
    ccp_uses_this_timer <= 1'h0;
    special_event <= 1'h1;
    @(posedge mclk);
    special_event <= 1'h0;
    ccp_uses_this_timer <= 1'h1;
    rdc("trig_other_timer", SBTC_OFF_LOW, 8'h66);
    // Pin sees a rise before its first fall; that rise must not count, but the later neighbour pass counts all three rises
    for (int s = 0; s < 2; s++) begin
      neighbour_osc_en <= s[0];
      wr(SBTC_OFF_LOW, 8'h00);
      wr(SBTC_OFF_CTRL, s == 1 ? 8'h07 : 8'h03);
      repeat (6) begin
        repeat (8) @(posedge mclk);
        if (s == 1) neighbour_osc <= ~neighbour_osc;
        else external_count_pin <= ~external_count_pin;
      end
      repeat (8) @(posedge mclk);
      wr(SBTC_OFF_CTRL, 8'h00);
      rdc("edges", SBTC_OFF_LOW, s == 1 ? 8'h03 : 8'h02);
    end
    wr(SBTC_OFF_CTRL, 8'h80);
    wr(SBTC_OFF_HIGH, 8'h12);
    wr(SBTC_OFF_LOW, 8'h34);
    wr(SBTC_OFF_HIGH, 8'h77);
    rdc("low", SBTC_OFF_LOW, 8'h34);
    rdc("buffer", SBTC_OFF_HIGH, 8'h12);
    wr(SBTC_OFF_CTRL, 8'h00);
    rdc("high", SBTC_OFF_HIGH, 8'h12);
    rd(6'h14);
    chk("rresp", 32'(SBTC_RESP_SLVERR), 32'(resp));
    wr(6'h14, 8'hFF);
    chk("bresp", 32'(SBTC_RESP_SLVERR), 32'(resp));
    stop_test;
  end
endmodule // tb_top
bind sbtc_top sbtc_properties sbtc_properties_i (.mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq);
